// >>> hdl/api_sequence_timing_control.sv
// Sequence-control front end of the automatic program interrupt unit.
`timescale 1ns/1ps
module api_sequence_timing_control
    import api_seq_pkg::*;
(
    input wire logic core_clk_i, // System clock, 100 MHz
    input wire logic sys_rst_i, // Asynchronous reset, active high
    input wire logic upper_group_request_i, // Upper group request
    input wire logic lower_group_request_i, // Lower group request
    input wire logic [LINE_COUNT-1:0] line_request_i, // Interrupt lines; 0 to 2 are group B
    input wire logic [7:0] response_addr_i, // Address from generator
    input wire logic [7:0] au_fetch_addr_i, // Normal fetch address
    input wire logic au_interrupt_enable_i, // AU allows interrupt
    input wire logic seq_step_one_i, // AU sequence count step one
    input wire logic cycle_end_i, // End of current AU time cycle
    output logic no_interrupt_present_main_o, // High while idle
    output logic no_interrupt_present_aux_o, // Auxiliary copy
    output logic time_counter_enable_o, // Timer stepping enable
    output logic timer_ff_first_o, // First timer flip-flop
    output logic timer_ff_second_o, // Second timer flip-flop
    output logic step_three_enable_o, // Timer done, grant armed
    output logic watchdog_monitor_o, // Monitor point copy
    output logic watchdog_fault_o, // Sticky watchdog fault
    output logic group_b_block_o, // Inhibit lower-priority gates
    output logic grant_ff_first_o, // First grant flip-flop
    output logic grant_ff_second_o, // Second grant flip-flop
    output logic [7:0] mem_addr_o, // Address of next fetch
    output logic pc_inhibit_o, // Hold program counter
    output logic [7:0] priority_o, // Held priority flip-flops
    output logic clear_priority_a_o, // Clear priority, first
    output logic clear_priority_b_o // Clear priority, second
);
    // Control cycle phases, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1, // No interrupt in progress
        ST_TIME = 4'h2, // Timer settling the address
        ST_GRANT = 4'h4, // Response fetch under way
        ST_HOLD = 4'h8 // Waiting for the following instruction
    } phase_t;

    phase_t phase; // Current phase
    phase_t next_phase;
    logic t1; // First timer flip-flop
    logic t2; // Second timer flip-flop
    logic next_t1;
    logic next_t2;
    logic g1; // First grant
    logic g2; // Second grant
    logic next_g1;
    logic next_g2;
    logic [7:0] prio; // Priority flip-flops
    logic [7:0] next_prio;
    logic request; // Any group request present
    logic tce; // Time counter enable gate
    logic step3_gate; // AND of both timers
    logic clear_pri; // Clear-priority condition
    logic [LINE_COUNT-1:0] grp_b_sel; // Lines taking part in group B
    logic [7:0] next_addr;

    // Only lines 0 through 2 form the group-B block
    genvar gi;
    generate
        for (gi = 0; gi < LINE_COUNT; gi++) begin : g_grpb
            assign grp_b_sel[gi] = line_request_i[gi] &&
                (gi >= GROUP_B_FIRST) && (gi <= GROUP_B_LAST);
        end
    endgenerate

    // Request combining and timer gating
    always_comb begin
        request = upper_group_request_i || lower_group_request_i;
        tce = request && !(t1 && t2);
        step3_gate = t1 && t2;
        clear_pri = g2 && !g1 && seq_step_one_i && cycle_end_i;
    end

    // Next state of timers, grants, priority and fetch address
    always_comb begin
        next_t1 = t1;
        next_t2 = t2;
        next_g1 = g1;
        next_g2 = g2;
        next_prio = prio;
        next_phase = phase;
        next_addr = au_fetch_addr_i;
        // JK action: first toggles while enabled, second sets after it
        if (tce) begin
            next_t1 = !t1;
            if (t1) begin
                next_t2 = 1'b1;
            end
        end
        // Priority follows requests only until the lockout drops
        if (phase == ST_IDLE || phase == ST_TIME) begin
            if (no_interrupt_present_main_o) begin
                next_prio = line_request_i;
            end
        end
        case (phase)
            ST_IDLE: begin
                if (request) begin
                    next_phase = ST_TIME;
                end
            end
            ST_TIME: begin
                // Grant may wait indefinitely for the AU enable
                if (step_three_enable_o && au_interrupt_enable_i && !g2) begin
                    next_g1 = 1'b1;
                    next_phase = ST_GRANT;
                end
            end
            ST_GRANT: begin
                next_addr = response_addr_i;
                if (seq_step_one_i) begin
                    next_g2 = 1'b1;
                end
                if (g2 && seq_step_one_i && cycle_end_i) begin
                    next_g1 = 1'b0;
                    next_phase = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (clear_pri) begin
                    next_t1 = 1'b0;
                    next_t2 = 1'b0;
                    next_g2 = 1'b0;
                    next_prio = '0;
                    next_phase = ST_IDLE;
                end
            end
            default: begin
                next_phase = ST_IDLE;
            end
        endcase
    end

    // Register all sequence state; reset leaves no cycle in progress
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase <= ST_IDLE;
            t1 <= TIMER_RESET;
            t2 <= TIMER_RESET;
            g1 <= 1'b0;
            g2 <= 1'b0;
            prio <= '0;
            no_interrupt_present_main_o <= 1'b1;
            no_interrupt_present_aux_o <= 1'b1;
            time_counter_enable_o <= 1'b0;
            step_three_enable_o <= 1'b0;
            watchdog_monitor_o <= 1'b0;
            group_b_block_o <= 1'b0;
            mem_addr_o <= 8'h00;
            pc_inhibit_o <= 1'b0;
            clear_priority_a_o <= 1'b0;
            clear_priority_b_o <= 1'b0;
        end else begin
            phase <= next_phase;
            t1 <= next_t1;
            t2 <= next_t2;
            g1 <= next_g1;
            g2 <= next_g2;
            prio <= next_prio;
            no_interrupt_present_main_o <= !request;
            no_interrupt_present_aux_o <= !request;
            time_counter_enable_o <= tce;
            // Registered copy of the AND gate acts as the buffer
            step_three_enable_o <= step3_gate;
            watchdog_monitor_o <= step3_gate;
            group_b_block_o <= |grp_b_sel;
            mem_addr_o <= next_addr;
            pc_inhibit_o <= (next_phase == ST_GRANT);
            clear_priority_a_o <= clear_pri;
            clear_priority_b_o <= clear_pri;
        end
    end

    assign timer_ff_first_o = t1;
    assign timer_ff_second_o = t2;
    assign grant_ff_first_o = g1;
    assign grant_ff_second_o = g2;
    assign priority_o = prio;

    // Watchdog on the buffered monitor point
    api_watchdog u_watchdog (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .monitor_i(watchdog_monitor_o),
        .fault_o(watchdog_fault_o)
    );

    // Timer reaches both-set three clocks after enable from idle
    AST_THREE_CLOCKS: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (tce && !t1 && !t2) |=> (t1 && !t2) ##1 (!t1 && t2) ##1 (t1 && t2))
        else $error("timer sequence wrong");
    AST_STOP: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (t1 && t2 && !clear_pri) |=> (t1 && t2))
        else $error("timer stepped after both set");
    AST_NO_REQ: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (!request && !clear_pri) |=> ($stable(t1) && $stable(t2)))
        else $error("timer moved without request");
    AST_STEP3: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        step_three_enable_o == $past(t1 && t2))
        else $error("step three enable wrong");
    AST_MONITOR: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        watchdog_monitor_o == step_three_enable_o)
        else $error("monitor differs from step three");
    AST_NIP: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        request |=> !no_interrupt_present_main_o && !no_interrupt_present_aux_o)
        else $error("no-interrupt-present stayed high");
    AST_GRANT: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (phase == ST_TIME && step_three_enable_o && au_interrupt_enable_i
         && !g2) |=> g1)
        else $error("grant did not set");
    AST_CLEAR: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (phase == ST_HOLD && clear_pri) |=> (!t1 && !t2 && prio == 8'h00))
        else $error("clear priority missed");
    AST_GROUPB: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        group_b_block_o == $past(|line_request_i[2:0]))
        else $error("group B block wrong");
    AST_ADDR: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (phase == ST_GRANT) |=> mem_addr_o == $past(response_addr_i))
        else $error("fetch address not from interrupt");
    COV_STEP3: cover property (@(posedge core_clk_i) step_three_enable_o);
    COV_GRANT: cover property (@(posedge core_clk_i) $rose(g1));
    COV_CLEAR: cover property (@(posedge core_clk_i) clear_priority_a_o);
endmodule

// >>> hdl/api_seq_pkg.sv
// Constants for the interrupt sequence timing control block.
package api_seq_pkg;
    // Number of interrupt lines presented by the address generator
    localparam int LINE_COUNT = 8;
    // Index of the first group-B line within the request vector
    localparam int GROUP_B_FIRST = 0;
    // Index of the last group-B line that raises the group-B block
    localparam int GROUP_B_LAST = 2;
    // Watchdog preset time in nanoseconds
    localparam int WATCHDOG_TIME_NS = 20000;
    // Clock period in nanoseconds
    localparam int CLK_PERIOD_NS = 10;
    // Longest time rounds down to whole cycles
    localparam int WATCHDOG_CYCLES = WATCHDOG_TIME_NS / CLK_PERIOD_NS;
    // Width of the watchdog counter
    localparam int WATCHDOG_W = 16;
    // Clocks from request until both timers are set; step-three enable follows one clock later
    localparam int SETTLE_CLOCKS = 3;
    // Timer state values
    localparam logic TIMER_RESET = 1'h0;
endpackage

// >>> hdl/api_watchdog.sv
// Watchdog that flags a timer held set beyond the preset time.
`timescale 1ns/1ps
module api_watchdog
    import api_seq_pkg::*;
#(
    parameter logic [WATCHDOG_W-1:0] LIMIT = WATCHDOG_W'(WATCHDOG_CYCLES)
) (
    input wire logic core_clk_i, // System clock
    input wire logic sys_rst_i, // Asynchronous reset, active high
    input wire logic monitor_i, // Step-three monitor point
    output logic fault_o // Sticky watchdog fault
);
    logic [WATCHDOG_W-1:0] count; // Cycles the monitor has stood high
    logic [WATCHDOG_W-1:0] next_count;
    logic next_fault;

    // Count while the monitor stays high; a drop restarts the count
    always_comb begin
        next_count = count;
        next_fault = fault_o;
        if (!monitor_i) begin
            next_count = '0;
        end else if (count >= LIMIT) begin
            next_fault = 1'b1; // Held too long
        end else begin
            next_count = count + WATCHDOG_W'(1);
        end
    end

    // Register the watchdog state
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            count <= '0;
            fault_o <= 1'b0;
        end else begin
            count <= next_count;
            fault_o <= next_fault;
        end
    end
endmodule

// >>> bench/au_seq_model.sv
// Partner model of the arithmetic unit sequence counter side.
`timescale 1ns/1ps
module au_seq_model (
    input wire logic core_clk_i, // System clock
    input wire logic sys_rst_i, // Asynchronous reset, active high
    input wire logic hold_off_i, // Bench withholds the enable
    output logic au_interrupt_enable_o, // AU allows interrupt
    output logic seq_step_one_o, // Sequence count step one
    output logic cycle_end_o // End of AU time cycle
);
    logic [1:0] phase; // AU time counter slot
    logic [1:0] next_phase; // Next slot
    // Four-slot time counter; step one covers the first two slots
    always_comb begin
        next_phase = phase + 2'h1;
    end
    // Register the slot
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            phase <= 2'h0;
        end else begin
            phase <= next_phase;
        end
    end
    // Withholding models a long non-interruptible instruction run
    assign au_interrupt_enable_o = !hold_off_i;
    assign seq_step_one_o = !phase[1];
    assign cycle_end_o = (phase == 2'h1); // Last slot of step one
endmodule

// >>> bench/tb_top.sv
// Self-checking bench for the interrupt sequence timing control.
`timescale 1ns/1ps
module tb_top;
    import api_seq_pkg::*;
    logic clk = 1'b0, rst = 1'b1, upr = 1'b0, lwr = 1'b0, hold = 1'b0;
    logic [7:0] lines = 8'h00, resp = 8'h00, fetch = 8'h00;
    logic aen, st1, cend, nm, na, tce, t1, t2, s3, mon, flt, gbb, g1, g2;
    logic pci, cpa, cpb;
    logic [7:0] maddr, prio;
    logic [31:0] seed = 32'h4E6E737A; // Fixed seed, repeatable run
    int num_errors = 0, n_compared = 0, cycles = 0;
    // Clock at 100 MHz
    initial begin
        forever #5 clk = ~clk;
    end
    api_sequence_timing_control uut (.core_clk_i(clk), .sys_rst_i(rst),
        .upper_group_request_i(upr), .lower_group_request_i(lwr),
        .line_request_i(lines), .response_addr_i(resp),
        .au_fetch_addr_i(fetch), .au_interrupt_enable_i(aen),
        .seq_step_one_i(st1), .cycle_end_i(cend),
        .no_interrupt_present_main_o(nm), .no_interrupt_present_aux_o(na),
        .time_counter_enable_o(tce), .timer_ff_first_o(t1),
        .timer_ff_second_o(t2), .step_three_enable_o(s3),
        .watchdog_monitor_o(mon), .watchdog_fault_o(flt),
        .group_b_block_o(gbb), .grant_ff_first_o(g1),
        .grant_ff_second_o(g2), .mem_addr_o(maddr), .pc_inhibit_o(pci),
        .priority_o(prio), .clear_priority_a_o(cpa),
        .clear_priority_b_o(cpb));
    au_seq_model au (.core_clk_i(clk), .sys_rst_i(rst), .hold_off_i(hold),
        .au_interrupt_enable_o(aen), .seq_step_one_o(st1),
        .cycle_end_o(cend));
    // Maximal-length style shift register for stimulus
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Compare one result
    task automatic chk(input string what, input logic [7:0] e,
        input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            $display("BAD %s exp %h got %h", what, e, g);
            num_errors++;
        end
    endtask
    // Verdict and end of run
    task automatic wrap_up();
        if (num_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Idle state: no cycle in progress, lockout open
    task automatic chk_idle();
        chk("idle", 8'h03, {6'h00, nm, na});
        chk("idle_ff", 8'h00, {2'h0, t1, t2, s3, mon, g1, g2});
        chk("prio", 8'h00, prio);
    endtask
    // One full interrupt control cycle with random addresses
    task automatic run(input bit dog);
        logic [7:0] l0;
        int k;
        bit sa, sc;
        seed = lfsr(seed);
        l0 = seed[7:0];
        lines = l0;
        resp = seed[15:8];
        fetch = seed[23:16];
        hold = dog;
        @(negedge clk);
        chk("fetch", fetch, maddr);
        chk("gbb", {7'h00, |l0[2:0]}, {7'h00, gbb});
        upr = 1'b1;
        lwr = 1'b1;
        @(negedge clk);
        chk("nip", 8'h00, {6'h00, nm, na});
        chk("tce1", 8'h01, {7'h00, tce});
        chk("tim1", 8'h02, {6'h00, t1, t2});
        chk("prio", l0, prio);
        lines = ~l0; // Late request must not disturb priority
        @(negedge clk);
        chk("tim2", 8'h01, {6'h00, t1, t2});
        chk("prio", l0, prio);
        @(negedge clk);
        chk("tim3", 8'h03, {6'h00, t1, t2});
        @(negedge clk);
        chk("s3", 8'h03, {6'h00, s3, mon});
        chk("tce4", 8'h00, {7'h00, tce});
        if (dog) begin
            repeat (WATCHDOG_CYCLES - 100) @(negedge clk);
            chk("flt0", 8'h00, {7'h00, flt});
            repeat (200) @(negedge clk);
            chk("flt1", 8'h01, {7'h00, flt});
            chk("nogrant", 8'h00, {7'h00, g1});
            hold = 1'b0;
        end
        for (k = 0; k < 20 && g1 !== 1'b1; k++) @(negedge clk);
        chk("grant", 8'h01, {7'h00, g1});
        upr = 1'b0;
        lwr = 1'b0;
        lines = 8'h00;
        sa = 0;
        sc = 0;
        // Collect the fetch address and clears over the whole cycle
        // Sample after each edge: the clear pulse stands one cycle only,
        // in the cycle in which the timers already read zero
        for (k = 0; k < 60 && (g1 | g2 | t1 | t2) !== 1'b0; k++) begin
            @(negedge clk);
            if (maddr === resp && pci === 1'b1) sa = 1;
            if (cpa === 1'b1 && cpb === 1'b1) sc = 1;
        end
        chk("resp", 8'h01, {7'h00, sa});
        chk("clr", 8'h01, {7'h00, sc});
        @(negedge clk);
        chk_idle();
        if (dog) begin
            chk("sticky", 8'h01, {7'h00, flt});
            rst = 1'b1;
            @(negedge clk);
            chk("rstflt", 8'h00, {7'h00, flt});
            rst = 1'b0;
        end
    endtask
    // Hang guard sized well above the expected run length
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    // Main sequence
    initial begin
        repeat (20) @(negedge clk);
        chk_idle();
        chk("flt", 8'h00, {7'h00, flt});
        rst = 1'b0;
        for (int i = 0; i < 40; i++) run(i == 5);
        wrap_up();
    end
endmodule
